// *** inc/ssm_pkg.sv ***
// shared constants for the soft-step and soft-mute controller
package ssm_pkg;
    // clock rate, used to turn times into cycle counts
    localparam int unsigned CLK_MHZ = 25;

    // register byte offsets on the bus
    localparam logic [7:0] REG_MUTE = 8'h00;
    localparam logic [7:0] REG_STEP_EN = 8'h04;
    localparam logic [7:0] REG_STEP_CFG = 8'h08;
    localparam logic [7:0] REG_BLK_BASE = 8'h0c;
    localparam logic [7:0] REG_FILT = 8'h24;
    localparam logic [7:0] REG_TEST = 8'h28;
    localparam logic [7:0] REG_STATUS = 8'h2c;

    // gain blocks that can ramp, one data register each
    localparam int NBLK = 6;
    localparam int BLK_LOUD = 0;
    localparam int BLK_VOL = 1;
    localparam int BLK_TREB = 2;
    localparam int BLK_MID = 3;
    localparam int BLK_BASS = 4;
    localparam int BLK_SPK = 5;

    // field positions
    localparam int MUTE_BUS_OFF = 0;
    localparam int MUTE_BUS_ONLY = 1;
    localparam int MUTE_TIME_LO = 2;
    localparam int MUTE_SUB_SRC = 4;
    localparam int MUTE_SUB_OFF = 5;
    localparam int MUTE_FCHG_OFF = 6;
    localparam int MUTE_AA_OFF = 7;
    localparam int CFG_STEP_10MS = 3;
    localparam int CFG_WIN_LO = 4;
    localparam int CFG_SPIKE_LO = 6;
    localparam int BLK_ACT = 7;
    localparam int FILT_SUB_FC_LO = 0;
    localparam int FILT_SUB_PH0 = 2;
    localparam int FILT_MID_FC_LO = 3;
    localparam int FILT_BASS_FC_LO = 5;
    localparam int FILT_BASS_DC = 7;
    localparam int TEST_BYTE_D0 = 0;
    localparam int TEST_SUBADDR_D7 = 8;
    localparam int STAT_MUTE = 0;
    localparam int STAT_STEP_N = 1;
    localparam int STAT_FAULT_N = 2;

    // values after reset
    localparam logic [7:0] MUTE_RST = 8'hc1;
    localparam logic [7:0] STEP_EN_RST = 8'hff;
    localparam logic [7:0] STEP_CFG_RST = 8'h3f;
    localparam logic [7:0] BLK_RST = 8'h00;
    localparam logic [7:0] FILT_RST = 8'h7e;
    localparam logic [8:0] TEST_RST = 9'h000;

    // times in microseconds
    localparam int unsigned MUTE_T0_US = 480;
    localparam int unsigned MUTE_T1_US = 960;
    localparam int unsigned MUTE_T2_US = 7680;
    localparam int unsigned MUTE_T3_US = 15360;
    localparam int unsigned STEP_5_US = 5000;
    localparam int unsigned STEP_10_US = 10000;
    localparam int unsigned FCHG_US = 1000;

    // cycle counts derived from the times
    localparam int unsigned MUTE_T0_CYC = MUTE_T0_US * CLK_MHZ;
    localparam int unsigned MUTE_T1_CYC = MUTE_T1_US * CLK_MHZ;
    localparam int unsigned MUTE_T2_CYC = MUTE_T2_US * CLK_MHZ;
    localparam int unsigned MUTE_T3_CYC = MUTE_T3_US * CLK_MHZ;
    localparam int unsigned STEP_5_CYC = STEP_5_US * CLK_MHZ;
    localparam int unsigned STEP_10_CYC = STEP_10_US * CLK_MHZ;
    localparam int unsigned FCHG_CYC = FCHG_US * CLK_MHZ;

    localparam int CNT_W = 19;

    typedef enum logic [1:0] {
        MS_OPEN = 2'b00,
        MS_FALL = 2'b01,
        MS_SHUT = 2'b10,
        MS_RISE = 2'b11
    } ssm_mute_t;
endpackage : ssm_pkg

// *** rtl/ssm_top.sv ***
// soft-mute, soft-step sequencer, offset fault and settings, AHB-Lite slave
`timescale 1ns/100ps
module ssm_top
    import ssm_pkg::*;
#(
    parameter int unsigned MUTE_CYC0 = MUTE_T0_CYC,
    parameter int unsigned MUTE_CYC1 = MUTE_T1_CYC,
    parameter int unsigned MUTE_CYC2 = MUTE_T2_CYC,
    parameter int unsigned MUTE_CYC3 = MUTE_T3_CYC,
    parameter int unsigned STEP_CYC5 = STEP_5_CYC,
    parameter int unsigned STEP_CYC10 = STEP_10_CYC,
    parameter int unsigned FCHG_CYCLES = FCHG_CYC
) (
    input wire logic sys_clk, // 25 MHz clock
    input wire logic sys_rst, // async reset, active high
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size
    input wire logic hready, // bus ready in
    input wire logic [31:0] hwdata, // write data
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    input wire logic mute_pin_n, // external mute pin, low mutes
    input wire logic window_compare_in, // amplifier window comparator
    input wire logic outputs_in_window, // front and rear inside windows
    output logic offset_fault_out, // offset fault, active low
    output logic fast_charge_out, // charge window_delay_cap quickly
    output logic [1:0] window_size_sel, // zero window threshold
    output logic [1:0] spike_time_sel, // spike rejection constant
    output logic mute_active_flag, // mute ramp, hold or demute ramp in progress
    output logic mute_falling, // mute ramp running down
    output logic mute_rising, // demute ramp running up
    output logic [1:0] mute_slope_sel, // slope of the running ramp
    output logic ramp_in_progress_n, // low while a step ramp runs
    output logic [NBLK-1:0] ramp_mask, // blocks in the running ramp
    output logic step_10ms, // shared step time, high for 10 ms
    output logic [NBLK-1:0][6:0] block_gain, // applied block settings
    output logic loud_flat, // loudness in flat attenuator mode
    output logic [1:0] bass_fc_sel, // bass centre frequency
    output logic [1:0] bass_q_sel, // bass quality factor
    output logic bass_dc_mode, // bass DC mode
    output logic [1:0] mid_fc_sel, // middle centre frequency
    output logic [1:0] sub_fc_sel, // subwoofer cut-off
    output logic sub_phase_0, // subwoofer phase 0 deg when high
    output logic sub_from_bass, // subwoofer fed from bass output
    output logic sub_enable, // subwoofer outputs on
    output logic anti_alias_on, // anti-alias filter in path
    output logic test_mode, // internal probes on probe_input_left
    output logic probe_disconnect // input resistor off the probe pin
);

    function automatic logic [3:0] blk_slot(input logic [7:0] a);
        logic [7:0] rel;
        rel = a - REG_BLK_BASE;
        blk_slot = {(a >= REG_BLK_BASE) && (rel[7:2] < 6'(NBLK))
                    && (rel[1:0] == 2'b00), rel[4:2]};
    endfunction : blk_slot

    // bus address phase capture
    logic wr_pend_q;
    logic [7:0] waddr_q;
    logic [31:0] rdata_q;
    wire addr_ok = hsel && hready && htrans[1];
    wire [3:0] wslot = blk_slot(waddr_q);
    wire [3:0] rslot = blk_slot(haddr[7:0]);
    wire wr_go = wr_pend_q;

    logic [7:0] mute_reg_q;
    logic [7:0] step_en_q;
    logic [7:0] step_cfg_q;
    logic [7:0] filt_q;
    logic [8:0] test_q;
    logic [NBLK-1:0][7:0] blk_reg_q;

    wire wr_mute = wr_go && waddr_q == REG_MUTE;
    wire wr_en = wr_go && waddr_q == REG_STEP_EN;
    wire wr_cfg = wr_go && waddr_q == REG_STEP_CFG;
    wire wr_filt = wr_go && waddr_q == REG_FILT;
    wire wr_test = wr_go && waddr_q == REG_TEST;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;

    // synchronisers: 3 stages, a change counts when stages 2 and 3 agree
    logic [2:0] pin_s1_q;
    logic [2:0] pin_s2_q;
    logic [2:0] pin_s3_q;
    logic [2:0] pin_f_q;
    wire [2:0] pin_raw = {outputs_in_window, window_compare_in, mute_pin_n};
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            always_ff @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    pin_s1_q[g] <= 1'b1;
                    pin_s2_q[g] <= 1'b1;
                    pin_s3_q[g] <= 1'b1;
                    pin_f_q[g] <= 1'b1;
                end else begin
                    pin_s1_q[g] <= pin_raw[g];
                    pin_s2_q[g] <= pin_s1_q[g];
                    pin_s3_q[g] <= pin_s2_q[g];
                    if (pin_s2_q[g] == pin_s3_q[g]) begin
                        pin_f_q[g] <= pin_s3_q[g];
                    end
                end
            end
        end
    endgenerate
    wire pin_mute = ~pin_f_q[0];
    wire win_low = ~pin_f_q[1];
    wire in_win = pin_f_q[2];

    // soft-step sequencer state
    logic [NBLK-1:0] wait_q;
    logic fire_q;
    logic step_busy_q;
    logic [CNT_W-1:0] step_cnt_q;
    logic [NBLK-1:0] ramp_mask_q;
    logic [NBLK-1:0][6:0] stage_q;
    logic [NBLK-1:0][6:0] gain_q;

    wire [NBLK-1:0] ramp_en = ~step_en_q[NBLK-1:0];
    logic [NBLK-1:0] blk_wr;
    logic [NBLK-1:0] new_wait;
    logic [NBLK-1:0] new_act;
    generate
        for (g = 0; g < NBLK; g++) begin : g_blk
            assign blk_wr[g] = wr_go && wslot[3] && wslot[2:0] == 3'(g);
            assign new_wait[g] = blk_wr[g] && ramp_en[g];
            assign new_act[g] = new_wait[g] && !hwdata[BLK_ACT];
        end
    endgenerate

    // a ramp may start only once the previous one is over
    wire step_start = fire_q && !step_busy_q;
    wire step_done = step_busy_q && step_cnt_q == '0;
    wire [CNT_W-1:0] step_len = step_cfg_q[CFG_STEP_10MS] ?
        CNT_W'(STEP_CYC10 - 1) : CNT_W'(STEP_CYC5 - 1);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wait_q <= '0;
            fire_q <= 1'b0;
        end else begin
            // a fresh write wins over the clear at ramp start
            wait_q <= (step_start ? '0 : wait_q) | new_wait;
            fire_q <= (fire_q && !step_start) || (|new_act);
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            step_busy_q <= 1'b0;
            step_cnt_q <= '0;
            ramp_mask_q <= '0;
        end else if (step_start) begin
            step_busy_q <= 1'b1;
            step_cnt_q <= step_len;
            ramp_mask_q <= wait_q;
        end else if (step_done) begin
            step_busy_q <= 1'b0;
            ramp_mask_q <= '0;
        end else if (step_busy_q) begin
            step_cnt_q <= step_cnt_q - 1'b1;
        end
    end

    generate
        for (g = 0; g < NBLK; g++) begin : g_gain
            always_ff @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    stage_q[g] <= BLK_RST[6:0];
                    gain_q[g] <= BLK_RST[6:0];
                end else begin
                    if (blk_wr[g]) begin
                        stage_q[g] <= hwdata[6:0];
                    end
                    if (blk_wr[g] && !ramp_en[g]) begin
                        gain_q[g] <= hwdata[6:0];
                    end else if (step_start && wait_q[g]) begin
                        gain_q[g] <= stage_q[g];
                    end
                end
            end
        end
    endgenerate

    assign ramp_mask = ramp_mask_q;
    assign block_gain = gain_q;
    assign ramp_in_progress_n = ~step_busy_q;
    assign step_10ms = step_cfg_q[CFG_STEP_10MS];

    // soft-mute sequencing
    ssm_mute_t mstate_q;
    ssm_mute_t mstate_d;
    logic [CNT_W-1:0] mcnt_q;
    logic [1:0] mslope_q;
    wire bus_mute = !mute_reg_q[MUTE_BUS_OFF];
    wire pin_allowed = !mute_reg_q[MUTE_BUS_ONLY];
    wire mute_req = bus_mute || (pin_allowed && pin_mute);
    wire [1:0] tsel = mute_reg_q[MUTE_TIME_LO +: 2];
    wire [CNT_W-1:0] mute_len = (tsel == 2'b00) ? CNT_W'(MUTE_CYC0 - 1) :
        (tsel == 2'b01) ? CNT_W'(MUTE_CYC1 - 1) :
        (tsel == 2'b10) ? CNT_W'(MUTE_CYC2 - 1) :
        CNT_W'(MUTE_CYC3 - 1);
    wire mcnt_zero = mcnt_q == '0;

    always_comb begin
        mstate_d = mstate_q;
        case (mstate_q)
            MS_OPEN: begin
                if (mute_req) begin
                    mstate_d = MS_FALL;
                end
            end
            // a running ramp ignores the request until it ends
            MS_FALL: begin
                if (mcnt_zero) begin
                    mstate_d = MS_SHUT;
                end
            end
            MS_SHUT: begin
                if (!mute_req) begin
                    mstate_d = MS_RISE;
                end
            end
            MS_RISE: begin
                if (mcnt_zero) begin
                    mstate_d = MS_OPEN;
                end
            end
            default: begin
                mstate_d = MS_OPEN;
            end
        endcase
    end

    wire mload = (mstate_q == MS_OPEN && mstate_d == MS_FALL)
        || (mstate_q == MS_SHUT && mstate_d == MS_RISE);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mstate_q <= MS_OPEN;
            mcnt_q <= '0;
            mslope_q <= 2'b00;
        end else begin
            mstate_q <= mstate_d;
            if (mload) begin
                mcnt_q <= mute_len;
                mslope_q <= tsel; // slope fixed for the whole ramp
            end else if (!mcnt_zero) begin
                mcnt_q <= mcnt_q - 1'b1;
            end
        end
    end

    assign mute_active_flag = mstate_q != MS_OPEN;
    assign mute_falling = mstate_q == MS_FALL;
    assign mute_rising = mstate_q == MS_RISE;
    assign mute_slope_sel = mslope_q;

    // offset detector: fault output and power-on fast charge
    logic fault_n_q;
    logic [CNT_W-1:0] fchg_cnt_q;
    logic fchg_q;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fault_n_q <= 1'b1;
            fchg_cnt_q <= CNT_W'(FCHG_CYCLES - 1);
            fchg_q <= 1'b1;
        end else begin
            fault_n_q <= !(in_win && win_low);
            if (fchg_cnt_q != '0) begin
                fchg_cnt_q <= fchg_cnt_q - 1'b1;
            end
            // charge pulse after reset, or held on by software
            fchg_q <= fchg_cnt_q != '0 || !mute_reg_q[MUTE_FCHG_OFF];
        end
    end
    assign offset_fault_out = fault_n_q;
    assign fast_charge_out = fchg_q;
    assign window_size_sel = step_cfg_q[CFG_WIN_LO +: 2];
    assign spike_time_sel = step_cfg_q[CFG_SPIKE_LO +: 2];

    // filter selections straight from their registers
    assign loud_flat = blk_reg_q[BLK_LOUD][5:4] == 2'b00;
    assign bass_q_sel = blk_reg_q[BLK_BASS][6:5];
    assign bass_fc_sel = filt_q[FILT_BASS_FC_LO +: 2];
    assign bass_dc_mode = filt_q[FILT_BASS_DC];
    assign mid_fc_sel = filt_q[FILT_MID_FC_LO +: 2];
    assign sub_fc_sel = filt_q[FILT_SUB_FC_LO +: 2];
    assign sub_phase_0 = filt_q[FILT_SUB_PH0];
    assign sub_from_bass = mute_reg_q[MUTE_SUB_SRC];
    assign sub_enable = !mute_reg_q[MUTE_SUB_OFF];
    assign anti_alias_on = !mute_reg_q[MUTE_AA_OFF];
    assign test_mode = test_q[TEST_SUBADDR_D7] && test_q[TEST_BYTE_D0];
    assign probe_disconnect = test_mode;

    // register writes, one data phase after the address phase
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_pend_q <= 1'b0;
            waddr_q <= 8'h00;
            mute_reg_q <= MUTE_RST;
            step_en_q <= STEP_EN_RST;
            step_cfg_q <= STEP_CFG_RST;
            filt_q <= FILT_RST;
            test_q <= TEST_RST;
        end else begin
            wr_pend_q <= addr_ok && hwrite;
            waddr_q <= haddr[7:0];
            if (wr_mute) begin
                mute_reg_q <= hwdata[7:0];
            end
            if (wr_en) begin
                step_en_q <= hwdata[7:0];
            end
            if (wr_cfg) begin
                step_cfg_q <= hwdata[7:0];
            end
            if (wr_filt) begin
                filt_q <= hwdata[7:0];
            end
            if (wr_test) begin
                test_q <= hwdata[8:0];
            end
        end
    end

    generate
        for (g = 0; g < NBLK; g++) begin : g_breg
            always_ff @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    blk_reg_q[g] <= BLK_RST;
                end else if (blk_wr[g]) begin
                    blk_reg_q[g] <= hwdata[7:0];
                end
            end
        end
    endgenerate

    // read data chosen in the address phase, held for the data phase
    logic [31:0] rd_word;
    wire [7:0] status_byte = {5'h00, fault_n_q, ~step_busy_q,
                              mute_active_flag};
    always_comb begin
        rd_word = 32'h0000_0000;
        if (rslot[3]) begin
            rd_word = {24'h000000, blk_reg_q[rslot[2:0]]};
        end else begin
            case (haddr[7:0])
                REG_MUTE: rd_word = {24'h000000, mute_reg_q};
                REG_STEP_EN: rd_word = {24'h000000, step_en_q};
                REG_STEP_CFG: rd_word = {24'h000000, step_cfg_q};
                REG_FILT: rd_word = {24'h000000, filt_q};
                REG_TEST: rd_word = {23'h000000, test_q};
                REG_STATUS: rd_word = {24'h000000, status_byte};
                default: rd_word = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            rdata_q <= rd_word;
        end
    end

endmodule : ssm_top

// *** tb/ssm_top_chk.sv ***
// assertions on the ports of the soft-mute and soft-step controller
`timescale 1ns/100ps
module ssm_top_chk
    import ssm_pkg::*;
(
    input wire logic sys_clk, // clock
    input wire logic sys_rst, // async reset
    input wire logic window_compare_in, // amp comparator
    input wire logic outputs_in_window, // outputs in window
    input wire logic offset_fault_out, // fault, low active
    input wire logic fast_charge_out, // fast charge
    input wire logic mute_active_flag, // mute flag
    input wire logic mute_falling, // mute ramp
    input wire logic mute_rising, // demute ramp
    input wire logic ramp_in_progress_n, // step busy, low
    input wire logic [NBLK-1:0] ramp_mask, // ramping blocks
    input wire logic step_10ms, // step time
    input wire logic test_mode, // test mode
    input wire logic probe_disconnect // probe resistor off
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    chk_fall_flag: assert property (
        mute_falling |-> mute_active_flag) else $error("flag low in mute");
    chk_rise_flag: assert property (
        mute_rising |-> mute_active_flag && !mute_falling)
        else $error("flag low in demute");
    chk_flag_end: assert property (
        $fell(mute_active_flag) |-> $past(mute_rising))
        else $error("flag dropped outside demute");
    chk_fall_run: assert property (
        $rose(mute_falling) |-> mute_falling[*8])
        else $error("mute ramp cut short");
    chk_step_len: assert property (
        $fell(ramp_in_progress_n) && !step_10ms |->
        !ramp_in_progress_n[*8] ##[1:3] ramp_in_progress_n)
        else $error("step ramp length wrong");
    chk_mask_hold: assert property (
        !ramp_in_progress_n && $past(!ramp_in_progress_n)
        |-> $stable(ramp_mask)) else $error("mask changed mid ramp");
    chk_busy_mask: assert property (
        !ramp_in_progress_n |-> ramp_mask != '0)
        else $error("ramp with no block");
    chk_fault_set: assert property (
        (outputs_in_window && !window_compare_in)[*8] |-> !offset_fault_out)
        else $error("fault not raised");
    chk_fault_clr: assert property (
        window_compare_in[*8] |-> offset_fault_out)
        else $error("fault without comparator low");
    chk_probe_pair: assert property (
        test_mode == probe_disconnect) else $error("probe pin mismatch");
    chk_fast_chg: assert property (
        $fell(sys_rst) |-> fast_charge_out[*4] ##[1:4] !fast_charge_out)
        else $error("fast charge span wrong");
    cover property ($rose(mute_rising));
    cover property ($fell(ramp_in_progress_n) && ramp_mask[BLK_VOL]);
    cover property ($fell(offset_fault_out));
endmodule : ssm_top_chk

// *** tb/ssm_amp_model.sv ***
// window comparator of the external power amplifier
`timescale 1ns/100ps
module ssm_amp_model (
    input wire logic amp_out_bad, // an amp output left its window
    output logic window_compare_in // comparator line to the device
);
    // drives the line low while an output is bad and drives it high otherwise
    assign window_compare_in = amp_out_bad ? 1'b0 : 1'b1;
endmodule : ssm_amp_model

// *** tb/ssm_top_bench.sv ***
// self-checking bench for the soft-mute and soft-step controller
`timescale 1ns/100ps
module ssm_top_bench
    import ssm_pkg::*;
;
    localparam int MC[4] = '{8, 12, 16, 20};
    logic sys_clk = 0, sys_rst = 1, hsel = 1, hwrite = 0, rd_ph = 0;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic mute_pin_n = 1, outputs_in_window = 0, amp_bad = 0;
    logic hreadyout, hresp, window_compare_in, offset_fault_out;
    logic fast_charge_out, mute_active_flag, mute_falling, mute_rising;
    logic ramp_in_progress_n, step_10ms, loud_flat, bass_dc_mode;
    logic sub_phase_0, sub_from_bass, sub_enable, anti_alias_on;
    logic test_mode, probe_disconnect;
    logic [1:0] window_size_sel, spike_time_sel, mute_slope_sel;
    logic [1:0] bass_fc_sel, bass_q_sel, mid_fc_sel, sub_fc_sel;
    logic [NBLK-1:0] ramp_mask;
    logic [NBLK-1:0][6:0] block_gain;
    logic [31:0] exp_q[$], len_q[$];
    logic [7:0] r;
    logic [6:0] g[3];
    int num_errors = 0, num_checks = 0, fcnt = 0, i, n;
    logic [7:0] ra[8] = '{REG_MUTE, REG_STEP_EN, REG_STEP_CFG,
        REG_BLK_BASE, REG_FILT, REG_TEST, REG_STATUS, 8'h30};
    logic [31:0] rv[8] = '{MUTE_RST, STEP_EN_RST, STEP_CFG_RST, BLK_RST,
        FILT_RST, TEST_RST, 32'h6, 32'h0};

    always #20 sys_clk = ~sys_clk;

    ssm_top #(.MUTE_CYC0(MC[0]), .MUTE_CYC1(MC[1]), .MUTE_CYC2(MC[2]),
        .MUTE_CYC3(MC[3]), .STEP_CYC5(10), .STEP_CYC10(20),
        .FCHG_CYCLES(5)) i_dut (.sys_clk, .sys_rst, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hready(hreadyout), .hwdata, .hrdata,
        .hreadyout, .hresp, .mute_pin_n, .window_compare_in,
        .outputs_in_window, .offset_fault_out, .fast_charge_out,
        .window_size_sel, .spike_time_sel, .mute_active_flag,
        .mute_falling, .mute_rising, .mute_slope_sel, .ramp_in_progress_n,
        .ramp_mask, .step_10ms, .block_gain, .loud_flat, .bass_fc_sel,
        .bass_q_sel, .bass_dc_mode, .mid_fc_sel, .sub_fc_sel, .sub_phase_0,
        .sub_from_bass, .sub_enable, .anti_alias_on, .test_mode,
        .probe_disconnect);
    ssm_amp_model i_amp (.amp_out_bad(amp_bad), .window_compare_in);

    task automatic check(input logic [31:0] seen, exp, input string nm);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic summarize;
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge sys_clk);
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        rd_ph <= !w;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd_ph <= 1'b0;
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd

    // read data and mute ramp lengths are judged against queued notes
    always @(posedge sys_clk) begin
        if (rd_ph && hreadyout) begin
            check(hrdata, exp_q.pop_front(), "rd");
            check(hresp, 1'b0, "resp");
        end
        if (mute_falling) fcnt <= fcnt + 1;
        else if (fcnt != 0) begin
            check(fcnt, len_q.pop_front(), "fall");
            fcnt <= 0;
        end
    end

    initial begin
        #400000;
        num_errors++;
        summarize();
    end

    initial begin
        void'($urandom(32'hf183));
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (i = 0; i < 8; i++) rd(ra[i], rv[i]);
        repeat (4) begin
            r = 8'($urandom);
            bus(1, REG_FILT, {24'h0, r});
            @(negedge sys_clk);
            check({bass_dc_mode, bass_fc_sel, mid_fc_sel, sub_phase_0,
                sub_fc_sel}, r, "filt");
        end
        for (i = 0; i < 4; i++) begin
            len_q.push_back(MC[i]);
            bus(1, REG_MUTE, 8'hc0 | i << 2);
            rd(REG_STATUS, 32'h7);
            @(negedge sys_clk);
            check(mute_slope_sel, i, "slope");
            bus(1, REG_MUTE, 8'hc1 | i << 2);
            for (n = 0; n < 100 && mute_active_flag !== 1'b0; n++)
                @(negedge sys_clk);
            check(mute_active_flag, 0, "demute");
        end
        len_q.push_back(MC[3]);
        @(posedge sys_clk) mute_pin_n <= 1'b0;
        for (n = 0; n < 20 && mute_active_flag !== 1'b1; n++)
            @(negedge sys_clk);
        check(mute_active_flag, 1, "pin mute");
        @(posedge sys_clk) mute_pin_n <= 1'b1;
        for (n = 0; n < 100 && mute_active_flag !== 1'b0; n++)
            @(negedge sys_clk);
        bus(1, REG_MUTE, 8'hdf);
        @(posedge sys_clk) mute_pin_n <= 1'b0;
        repeat (20) @(negedge sys_clk);
        check({mute_active_flag, sub_from_bass, sub_enable, anti_alias_on},
            4'b0110, "bus only");
        @(posedge sys_clk) mute_pin_n <= 1'b1;
        bus(1, REG_STEP_EN, 32'h0);
        bus(1, REG_STEP_CFG, 32'h37);
        @(negedge sys_clk);
        check({step_10ms, window_size_sel, spike_time_sel}, 5'b01100,
            "cfg");
        for (i = 0; i < 3; i++) g[i] = 7'($urandom);
        bus(1, 8'(REG_BLK_BASE + 4 * BLK_VOL), {25'h1, g[0]});
        bus(1, 8'(REG_BLK_BASE + 4 * BLK_TREB), {25'h1, g[1]});
        @(negedge sys_clk);
        check({ramp_in_progress_n, block_gain[BLK_VOL]}, 8'h80,
            "wait");
        bus(1, 8'(REG_BLK_BASE + 4 * BLK_BASS), {25'h0, g[2]});
        bus(1, 8'(REG_BLK_BASE + 4 * BLK_LOUD), 32'h03);
        for (n = 0; n < 20 && ramp_in_progress_n !== 1'b0; n++)
            @(negedge sys_clk);
        check(ramp_mask, 6'b010110, "batch");
        check({block_gain[BLK_BASS], block_gain[BLK_TREB],
            block_gain[BLK_VOL]}, {g[2], g[1], g[0]}, "gain");
        rd(REG_STATUS, 32'h4);
        // the host polls the busy flag before relying on the next ramp
        for (n = 0; n < 30 && ramp_in_progress_n !== 1'b1; n++)
            @(negedge sys_clk);
        for (n = 0; n < 5 && ramp_in_progress_n !== 1'b0; n++)
            @(negedge sys_clk);
        check(ramp_mask, 6'b000001, "queued");
        for (n = 0; n < 50 && ramp_in_progress_n === 1'b0; n++)
            @(negedge sys_clk);
        check(n, 10, "step len");
        check({loud_flat, block_gain[BLK_LOUD]}, 8'h83, "flat");
        bus(1, REG_STEP_EN, 32'h20);
        bus(1, 8'(REG_BLK_BASE + 4 * BLK_SPK), 32'h05);
        repeat (2) @(negedge sys_clk);
        check({ramp_in_progress_n, block_gain[BLK_SPK]}, 8'h85,
            "direct");
        // the long step time is the reset choice, so it needs its own ramp
        bus(1, REG_STEP_CFG, 32'h08);
        bus(1, 8'(REG_BLK_BASE + 4 * BLK_VOL), 32'h11);
        for (n = 0; n < 10 && ramp_in_progress_n !== 1'b0; n++)
            @(negedge sys_clk);
        check(ramp_mask, 6'b000010, "mask 10ms");
        for (n = 0; n < 50 && ramp_in_progress_n === 1'b0; n++)
            @(negedge sys_clk);
        check(n, 20, "step 10ms");
        check(block_gain[BLK_VOL], 7'h11, "gain 10ms");
        for (i = 0; i < 4; i++) begin
            @(posedge sys_clk) {amp_bad, outputs_in_window} <= 2'(i);
            repeat (10) @(negedge sys_clk);
            check(offset_fault_out, i != 3, "fault");
            rd(REG_STATUS, {29'h0, i != 3, 2'b10});
        end
        for (i = 1; i < 4; i++) begin
            bus(1, REG_TEST, {23'h0, i[1], 7'h0, i[0]});
            @(negedge sys_clk);
            check({test_mode, probe_disconnect}, {2{i == 3}},
                "test");
        end
        summarize();
    end
endmodule : ssm_top_bench

bind ssm_top ssm_top_chk i_chk (.sys_clk, .sys_rst, .window_compare_in,
    .outputs_in_window, .offset_fault_out, .fast_charge_out,
    .mute_active_flag, .mute_falling, .mute_rising, .ramp_in_progress_n,
    .ramp_mask, .step_10ms, .test_mode, .probe_disconnect);
